// file: banked_core_defs.vh
// shared constants for the banked core register block
// assumes a single 50 MHz system clock domain
`ifndef BANKED_CORE_DEFS_VH
`define BANKED_CORE_DEFS_VH

// memory organisation
`define BANK_COUNT        6'h20
`define BANK_SIZE         8'h80
`define ADDR_W            12
`define BANK_MSB          11
`define BANK_LSB          7
`define OFFS_MSB          6

// in-bank regions
`define CORE_REGION_END   7'h0C
`define SFR_REGION_END    7'h20
`define GPR_REGION_END    7'h70
`define GPR_BYTES_PER_BANK 8'h50
`define GPR_BANKS         5'h02
`define COMMON_BASE_IDX   8'hA0
`define RAM_DEPTH         176

// core register offsets
`define OFS_INDIRECT_ZERO 7'h00
`define OFS_INDIRECT_ONE  7'h01
`define OFS_PC_LOW        7'h02
`define OFS_STATUS        7'h03
`define OFS_PTR0_LOW      7'h04
`define OFS_PTR0_HIGH     7'h05
`define OFS_PTR1_LOW      7'h06
`define OFS_PTR1_HIGH     7'h07
`define OFS_BANK_SEL      7'h08
`define OFS_WORKING       7'h09
`define OFS_PC_LATCH_HIGH 7'h0A
`define OFS_INT_CONTROL   7'h0B

// status bit positions
`define ST_TIMEOUT        4
`define ST_POWERDOWN      3
`define ST_ZERO           2
`define ST_DIGIT_CARRY    1
`define ST_CARRY          0

// interrupt control bit positions
`define IC_GLOBAL_EN      7
`define IC_PERIPH_EN      6
`define IC_TIMER0_EN      5
`define IC_EXT_PIN_EN     4
`define IC_PIN_CHANGE_EN  3
`define IC_TIMER0_FLAG    2
`define IC_EXT_PIN_FLAG   1
`define IC_PIN_CHANGE_FLAG 0

// widths of the narrow core registers and the pointer high-nibble pad
`define BANK_SEL_W        5
`define PC_LATCH_W        7
`define PTR_HIGH_PAD      4'h0

// alu operation codes
`define ALU_NONE          3'h0
`define ALU_ADD           3'h1
`define ALU_SUB           3'h2
`define ALU_ROR           3'h3
`define ALU_ROL           3'h4
`define ALU_AND           3'h5
`define ALU_IOR           3'h6
`define ALU_XOR           3'h7

`endif

// file: alu_flag_unit.v
// arithmetic/logic unit with zero, digit carry and carry generation
// assumes operands are stable for the cycle of the write that uses them
`timescale 1ns/1ps
`default_nettype none
`include "banked_core_defs.vh"

module alu_flag_unit (
  input  wire [2:0] op,
  input  wire [7:0] opa,
  input  wire [7:0] opb,
  input  wire       carry_in,
  output reg  [7:0] result,
  output reg        zero,
  output reg        digit_carry,
  output reg        carry,
  output reg        affects_zero,
  output reg        affects_carries,
  output reg        affects_carry_only
);

  reg [8:0] sum;
  reg [4:0] nib;
  reg [7:0] addend;

  always @*
  begin
    sum = 9'h000;
    nib = 5'h00;
    addend = opb;
    result = 8'h00;
    carry = carry_in;
    digit_carry = 1'b0;
    affects_zero = 1'b0;
    affects_carries = 1'b0;
    affects_carry_only = 1'b0;
    case (op)
      `ALU_ADD, `ALU_SUB:
      begin
        // borrow shows as inverted carry
        addend = (op == `ALU_SUB) ? ~opb : opb;  // see R11
        sum = {1'b0, opa} + {1'b0, addend} + {8'h00, (op == `ALU_SUB)};
        nib = {1'b0, opa[3:0]} + {1'b0, addend[3:0]} + {4'h0, (op == `ALU_SUB)};
        result = sum[7:0];
        carry = sum[8];  // see R13
        digit_carry = nib[4];  // see R14
        affects_zero = 1'b1;
        affects_carries = 1'b1;
      end
      `ALU_ROR:
      begin
        result = {carry_in, opa[7:1]};
        carry = opa[0];  // see R12
        affects_carry_only = 1'b1;
      end
      `ALU_ROL:
      begin
        result = {opa[6:0], carry_in};
        carry = opa[7];  // see R12
        affects_carry_only = 1'b1;
      end
      `ALU_AND:
      begin
        result = opa & opb;
        affects_zero = 1'b1;
      end
      `ALU_IOR:
      begin
        result = opa | opb;
        affects_zero = 1'b1;
      end
      `ALU_XOR:
      begin
        result = opa ^ opb;
        affects_zero = 1'b1;
      end
      default:
      begin
        result = opb;
      end
    endcase
    zero = (result == 8'h00);  // see R22
  end

endmodule // alu_flag_unit
`default_nettype wire

// file: pointer_pair.v
// one file select pointer: low and high byte registers
// assumes write strobes come from the address decode of the bank
`timescale 1ns/1ps
`default_nettype none

module pointer_pair (
  input  wire        clk,
  input  wire        nrst,
  input  wire        wr_low,
  input  wire        wr_high,
  input  wire [7:0]  wdata,
  output wire [15:0] value
);

  reg [7:0] low_reg;
  reg [7:0] high_reg;

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      low_reg  <= 8'h00;
      high_reg <= 8'h00;
    end
    else
    begin
      if (wr_low)
        low_reg <= wdata;
      if (wr_high)
        high_reg <= wdata;
    end
  end

  assign value = {high_reg, low_reg};

endmodule // pointer_pair
`default_nettype wire

// file: banked_core_registers.v
// banked data memory with the core register set and interrupt control
// assumes the core issues one access per cycle and reads answer a cycle later
//
// Behaviour
// R1 - data memory is 32 banks of 128 locations each
// R2 - each bank: 12 core, 20 special, up to 80 general, 16 common bytes
// R3 - direct accesses use the bank last written into the bank selector
// R4 - unimplemented locations read as zero
// R5 - every location reachable directly or through either file pointer
// R6 - 12-bit address: upper five bits bank, lower seven in-bank offset
// R7 - core registers sit at offsets 0x00 to 0x0B of every bank in order
// R8 - status as destination: alu-affected flag bits take alu result, not data
// R9 - timeout and powerdown flags ignore all instruction writes
// R10 - software should alter status only with non-flag-affecting instructions
// R11 - subtraction adds two's complement; carries act as inverted borrows
// R12 - rotates load carry with the bit shifted out of the source
// R13 - add/subtract set carry on carry out of the top bit
// R14 - add/subtract set digit carry on carry out of bit three
// R15 - timeout and powerdown follow power-up, watchdog clear, sleep, time-out
// R16 - status: 7:5 zero, 4:3 read-only set at reset, 2:0 cleared by power-on
// R17 - interrupt control layout, all bits cleared on every reset; bit 0 here follows PIN_CHANGE_PENDING instead
// R18 - interrupt flags set on their condition regardless of enables
// R19 - software should clear a flag before setting its enable
// R20 - peripheral interrupts need the peripheral enable as well
// R21 - pin-change flag is read-only and follows the per-pin flags
// R22 - zero flag set when a result is zero, cleared otherwise
// R23 - interrupt request when global enable and any enabled flag set
`timescale 1ns/1ps
`default_nettype none
`include "banked_core_defs.vh"

module banked_core_registers (
  input  wire        CLK,
  input  wire        NRST,
  input  wire        POR_NRST,
  input  wire        ACCESS_VALID,
  input  wire        ACCESS_WRITE,
  input  wire [6:0]  FILE_OFFSET,
  input  wire [7:0]  WRITE_DATA,
  input  wire [2:0]  ALU_OP,
  input  wire [7:0]  ALU_A,
  input  wire [7:0]  ALU_B,
  input  wire [7:0]  PC_CURRENT_LOW,
  input  wire        WATCHDOG_CLEAR,
  input  wire        SLEEP_EXEC,
  input  wire        WATCHDOG_TIMEOUT,
  input  wire        TIMER0_OVERFLOW,
  input  wire        EXT_PIN_EVENT,
  input  wire        PIN_CHANGE_PENDING,
  input  wire        PERIPH_REQUEST,
  output wire [7:0]  READ_DATA,
  output wire        READ_VALID,
  output wire        PC_JUMP,
  output wire [14:0] PC_JUMP_TARGET,
  output wire [7:0]  WORKING_VALUE,
  output wire [7:0]  STATUS_VALUE,
  output wire        IRQ
);

  // state
  reg [`BANK_SEL_W-1:0] bank_sel_reg;
  reg [7:0]             working_reg;
  reg [`PC_LATCH_W-1:0] pc_latch_reg;
  reg                   timeout_reg;
  reg                   powerdown_reg;
  reg                   zero_reg;
  reg                   digit_carry_reg;
  reg                   carry_reg;
  reg [7:1]             int_ctrl_reg;
  reg [7:0]             int_ctrl_next;
  reg [7:0]             ram_reg [0:`RAM_DEPTH-1];
  reg [7:0]             read_data_reg;
  reg                   read_valid_reg;
  reg                   pc_jump_reg;
  reg [14:0]            pc_target_reg;
  reg                   irq_reg;

  // decode
  reg [`ADDR_W-1:0]     eff_addr;
  reg                   eff_ok;
  reg [4:0]             eff_bank;
  reg [6:0]             eff_offs;
  reg                   in_gpr;
  reg                   in_common;
  reg [7:0]             ram_idx;
  reg [7:0]             rd_value;
  reg [7:0]             status_byte;
  reg [7:0]             int_ctrl_byte;

  wire [15:0]           ptr0_value;
  wire [15:0]           ptr1_value;
  wire [7:0]            alu_result;
  wire                  alu_zero;
  wire                  alu_digit_carry;
  wire                  alu_carry;
  wire                  alu_aff_zero;
  wire                  alu_aff_carries;
  wire                  alu_aff_carry_only;
  wire                  wr_en;
  wire                  flag_update;
  wire [7:0]            wdata;
  wire                  wr_status;

  alu_flag_unit u_alu (
    .op                 (ALU_OP),
    .opa                (ALU_A),
    .opb                (ALU_B),
    .carry_in           (carry_reg),
    .result             (alu_result),
    .zero               (alu_zero),
    .digit_carry        (alu_digit_carry),
    .carry              (alu_carry),
    .affects_zero       (alu_aff_zero),
    .affects_carries    (alu_aff_carries),
    .affects_carry_only (alu_aff_carry_only)
  );

  // direct uses the bank selector, ports use a pointer
  always @*
  begin
    eff_addr = {bank_sel_reg, FILE_OFFSET};                    // see R3, R6
    eff_ok   = 1'b1;
    if (FILE_OFFSET == `OFS_INDIRECT_ZERO)
    begin
      eff_addr = ptr0_value[`ADDR_W-1:0];                      // see R5
      eff_ok   = (ptr0_value[15:12] == `PTR_HIGH_PAD);
    end
    else if (FILE_OFFSET == `OFS_INDIRECT_ONE)
    begin
      eff_addr = ptr1_value[`ADDR_W-1:0];                      // see R5
      eff_ok   = (ptr1_value[15:12] == `PTR_HIGH_PAD);
    end
    eff_bank = eff_addr[`BANK_MSB:`BANK_LSB];                  // see R6, R1
    eff_offs = eff_addr[`OFFS_MSB:0];
    // a pointer aimed at an indirect port goes nowhere
    if ((FILE_OFFSET == `OFS_INDIRECT_ZERO || FILE_OFFSET == `OFS_INDIRECT_ONE) &&
        (eff_offs == `OFS_INDIRECT_ZERO || eff_offs == `OFS_INDIRECT_ONE))
      eff_ok = 1'b0;
  end

  // region and ram index; general ram is built for the first banks only
  always @*
  begin
    in_common = (eff_offs >= `GPR_REGION_END);                 // see R2
    in_gpr    = (eff_offs >= `SFR_REGION_END) && (eff_offs < `GPR_REGION_END) &&
                (eff_bank < `GPR_BANKS);                       // see R2
    ram_idx   = 8'h00;
    if (in_common)
      ram_idx = `COMMON_BASE_IDX + {1'b0, eff_offs - `GPR_REGION_END};
    else if (in_gpr)
      ram_idx = (eff_bank[0] ? `GPR_BYTES_PER_BANK : 8'h00) +
                {1'b0, eff_offs - `SFR_REGION_END};
  end

  always @*
  begin
    status_byte                  = 8'h00;                      // see R16
    status_byte[`ST_TIMEOUT]     = timeout_reg;
    status_byte[`ST_POWERDOWN]   = powerdown_reg;
    status_byte[`ST_ZERO]        = zero_reg;
    status_byte[`ST_DIGIT_CARRY] = digit_carry_reg;
    status_byte[`ST_CARRY]       = carry_reg;
    int_ctrl_byte                = {int_ctrl_reg, PIN_CHANGE_PENDING}; // see R21
  end

  // read mux
  always @*
  begin
    rd_value = 8'h00;                                          // see R4
    if (eff_ok)
    begin
      if (eff_offs < `CORE_REGION_END)
      begin
        case (eff_offs)                                        // see R7
          `OFS_PC_LOW:        rd_value = PC_CURRENT_LOW;
          `OFS_STATUS:        rd_value = status_byte;
          `OFS_PTR0_LOW:      rd_value = ptr0_value[7:0];
          `OFS_PTR0_HIGH:     rd_value = ptr0_value[15:8];
          `OFS_PTR1_LOW:      rd_value = ptr1_value[7:0];
          `OFS_PTR1_HIGH:     rd_value = ptr1_value[15:8];
          `OFS_BANK_SEL:      rd_value = {3'h0, bank_sel_reg};
          `OFS_WORKING:       rd_value = working_reg;
          `OFS_PC_LATCH_HIGH: rd_value = {1'b0, pc_latch_reg};
          `OFS_INT_CONTROL:   rd_value = int_ctrl_byte;
          default:            rd_value = 8'h00;
        endcase
      end
      else if (in_gpr || in_common)
        rd_value = ram_reg[ram_idx];
    end
  end

  assign wr_en       = ACCESS_VALID && ACCESS_WRITE && eff_ok;
  assign flag_update = ACCESS_VALID && ACCESS_WRITE && (ALU_OP != `ALU_NONE);
  assign wdata       = (ALU_OP != `ALU_NONE) ? alu_result : WRITE_DATA;
  assign wr_status   = wr_en && (eff_offs == `OFS_STATUS);

  pointer_pair u_ptr0 (
    .clk     (CLK),
    .nrst    (NRST),
    .wr_low  (wr_en && (eff_offs == `OFS_PTR0_LOW)),
    .wr_high (wr_en && (eff_offs == `OFS_PTR0_HIGH)),
    .wdata   (wdata),
    .value   (ptr0_value)
  );

  pointer_pair u_ptr1 (
    .clk     (CLK),
    .nrst    (NRST),
    .wr_low  (wr_en && (eff_offs == `OFS_PTR1_LOW)),
    .wr_high (wr_en && (eff_offs == `OFS_PTR1_HIGH)),
    .wdata   (wdata),
    .value   (ptr1_value)
  );

  // plain core registers
  always @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      bank_sel_reg <= {`BANK_SEL_W{1'b0}};
      working_reg  <= 8'h00;
      pc_latch_reg <= {`PC_LATCH_W{1'b0}};
    end
    else if (wr_en)
    begin
      if (eff_offs == `OFS_BANK_SEL)
        bank_sel_reg <= wdata[`BANK_SEL_W-1:0];                // see R3
      if (eff_offs == `OFS_WORKING)
        working_reg <= wdata;
      if (eff_offs == `OFS_PC_LATCH_HIGH)
        pc_latch_reg <= wdata[`PC_LATCH_W-1:0];
    end
  end

  // general and common ram
  always @(posedge CLK)
  begin
    if (wr_en && (in_gpr || in_common))
      ram_reg[ram_idx] <= wdata;                               // see R2
  end

  // alu flags survive every reset but power-on
  always @(posedge CLK or negedge POR_NRST)
  begin
    if (!POR_NRST)
    begin
      zero_reg        <= 1'b0;  // see R16
      digit_carry_reg <= 1'b0;
      carry_reg       <= 1'b0;
    end
    else
    begin
      if (flag_update && alu_aff_zero)
        zero_reg <= alu_zero;  // see R8, R22
      else if (wr_status)
        zero_reg <= wdata[`ST_ZERO];
      if (flag_update && alu_aff_carries)
        digit_carry_reg <= alu_digit_carry;  // see R8, R14
      else if (wr_status)
        digit_carry_reg <= wdata[`ST_DIGIT_CARRY];
      if (flag_update && (alu_aff_carries || alu_aff_carry_only))
        carry_reg <= alu_carry;  // see R8, R13
      else if (wr_status)
        carry_reg <= wdata[`ST_CARRY];
    end
  end

  // reset-cause flags: no write path at all
  always @(posedge CLK or negedge POR_NRST)
  begin
    if (!POR_NRST)
    begin
      timeout_reg   <= 1'b1;  // see R15, R16
      powerdown_reg <= 1'b1;
    end
    else
    begin
      // a time-out beats a clear or sleep in the same cycle
      if (WATCHDOG_TIMEOUT)
        timeout_reg <= 1'b0;  // see R15, R9
      else if (WATCHDOG_CLEAR || SLEEP_EXEC)
        timeout_reg <= 1'b1;
      if (SLEEP_EXEC)
        powerdown_reg <= 1'b0;  // see R15, R9
      else if (WATCHDOG_CLEAR)
        powerdown_reg <= 1'b1;
    end
  end

  // interrupt control: events win over a clearing write
  always @*
  begin
    int_ctrl_next = {int_ctrl_reg, 1'b0};
    if (wr_en && (eff_offs == `OFS_INT_CONTROL))
      int_ctrl_next = wdata;                                   // see R17
    if (TIMER0_OVERFLOW)
      int_ctrl_next[`IC_TIMER0_FLAG] = 1'b1;                   // see R18
    if (EXT_PIN_EVENT)
      int_ctrl_next[`IC_EXT_PIN_FLAG] = 1'b1;                  // see R18
  end

  always @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      int_ctrl_reg <= 7'h00;                                   // see R17
    else
      int_ctrl_reg <= int_ctrl_next[7:1];
  end

  // registered answers to the core
  always @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      read_data_reg  <= 8'h00;
      read_valid_reg <= 1'b0;
      pc_jump_reg    <= 1'b0;
      pc_target_reg  <= 15'h0000;
      irq_reg        <= 1'b0;
    end
    else
    begin
      read_valid_reg <= ACCESS_VALID && !ACCESS_WRITE;
      if (ACCESS_VALID && !ACCESS_WRITE)
        read_data_reg <= rd_value;                             // see R4
      // writing the low counter jumps using the latched high part
      pc_jump_reg <= wr_en && (eff_offs == `OFS_PC_LOW);
      if (wr_en && (eff_offs == `OFS_PC_LOW))
        pc_target_reg <= {pc_latch_reg, wdata};
      irq_reg <= int_ctrl_byte[`IC_GLOBAL_EN] &&               // see R23
                 ((int_ctrl_byte[`IC_TIMER0_EN] && int_ctrl_byte[`IC_TIMER0_FLAG]) ||
                  (int_ctrl_byte[`IC_EXT_PIN_EN] && int_ctrl_byte[`IC_EXT_PIN_FLAG]) ||
                  (int_ctrl_byte[`IC_PIN_CHANGE_EN] && int_ctrl_byte[`IC_PIN_CHANGE_FLAG]) ||
                  (int_ctrl_byte[`IC_PERIPH_EN] && PERIPH_REQUEST)); // see R20
    end
  end

  assign READ_DATA      = read_data_reg;
  assign READ_VALID     = read_valid_reg;
  assign PC_JUMP        = pc_jump_reg;
  assign PC_JUMP_TARGET = pc_target_reg;
  assign WORKING_VALUE  = working_reg;
  assign STATUS_VALUE   = status_byte;
  assign IRQ            = irq_reg;

endmodule // banked_core_registers
`default_nettype wire

// file: banked_core_checker_properties.sv
// port-level properties of the banked core register block
// assumes one clock and two active-low resets; bound below
`timescale 1ns/1ps
`default_nettype none
`include "banked_core_defs.vh"

module banked_core_checker (
  input wire logic        CLK,
  input wire logic        NRST,
  input wire logic        POR_NRST,
  input wire logic        ACCESS_VALID,
  input wire logic        ACCESS_WRITE,
  input wire logic [6:0]  FILE_OFFSET,
  input wire logic [7:0]  WRITE_DATA,
  input wire logic [2:0]  ALU_OP,
  input wire logic [7:0]  ALU_A,
  input wire logic [7:0]  ALU_B,
  input wire logic        WATCHDOG_CLEAR,
  input wire logic        SLEEP_EXEC,
  input wire logic        WATCHDOG_TIMEOUT,
  input wire logic [7:0]  READ_DATA,
  input wire logic        PC_JUMP,
  input wire logic [14:0] PC_JUMP_TARGET,
  input wire logic [7:0]  STATUS_VALUE
);
  wire logic       wr  = ACCESS_VALID & ACCESS_WRITE;
  wire logic       rd  = ACCESS_VALID & ~ACCESS_WRITE;
  wire logic       ev  = WATCHDOG_CLEAR | SLEEP_EXEC | WATCHDOG_TIMEOUT;
  wire logic [8:0] sum = {1'b0, ALU_A} + {1'b0, ALU_B};
  wire logic [4:0] nib = {1'b0, ALU_A[3:0]} + {1'b0, ALU_B[3:0]};

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST || !POR_NRST);

  property p_status_top;
    STATUS_VALUE[7:5] == 3'h0;
  endproperty
  a_status_top: assert property (p_status_top) else $error("status upper bits set");
  property p_jump;
    PC_JUMP == $past(wr && FILE_OFFSET == `OFS_PC_LOW);
  endproperty
  a_jump: assert property (p_jump) else $error("jump pulse wrong");
  property p_jump_low;
    wr && FILE_OFFSET == `OFS_PC_LOW && ALU_OP == `ALU_NONE |=>
      PC_JUMP_TARGET[7:0] == $past(WRITE_DATA);
  endproperty
  a_jump_low: assert property (p_jump_low) else $error("jump target wrong");
  property p_status_read;
    rd && FILE_OFFSET == `OFS_STATUS |=> READ_DATA == $past(STATUS_VALUE);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status readback wrong");
  property p_special;
    rd && FILE_OFFSET >= 7'h0C && FILE_OFFSET < `SFR_REGION_END |=> READ_DATA == 8'h00;
  endproperty
  a_special: assert property (p_special) else $error("unimplemented read not zero");
  property p_flags_hold;
    !ev |=> $stable(STATUS_VALUE[4:3]);
  endproperty
  a_flags_hold: assert property (p_flags_hold) else $error("reset flags moved");
  property p_timeout;
    WATCHDOG_TIMEOUT |=> !STATUS_VALUE[`ST_TIMEOUT];
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout flag not cleared");
  property p_sleep;
    SLEEP_EXEC && !WATCHDOG_TIMEOUT |=> STATUS_VALUE[4:3] == 2'h2;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep flags wrong");
  property p_wd_clear;
    WATCHDOG_CLEAR && !SLEEP_EXEC && !WATCHDOG_TIMEOUT |=> STATUS_VALUE[4:3] == 2'h3;
  endproperty
  a_wd_clear: assert property (p_wd_clear) else $error("clear flags wrong");
  property p_add;
    wr && ALU_OP == `ALU_ADD |=> STATUS_VALUE[1:0] == $past({nib[4], sum[8]});
  endproperty
  a_add: assert property (p_add) else $error("add carries wrong");
  property p_sub;
    wr && ALU_OP == `ALU_SUB |=> STATUS_VALUE[0] == $past(ALU_A >= ALU_B)
      && STATUS_VALUE[1] == $past(ALU_A[3:0] >= ALU_B[3:0]);
  endproperty
  a_sub: assert property (p_sub) else $error("borrow flags wrong");
  property p_rotate;
    wr && (ALU_OP == `ALU_ROR || ALU_OP == `ALU_ROL) |=>
      STATUS_VALUE[0] == $past(ALU_OP == `ALU_ROR ? ALU_A[0] : ALU_A[7]);
  endproperty
  a_rotate: assert property (p_rotate) else $error("rotate carry wrong");
  property p_zero;
    wr && ALU_OP == `ALU_XOR |=> STATUS_VALUE[`ST_ZERO] == $past(ALU_A == ALU_B);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
endmodule // banked_core_checker

bind banked_core_registers banked_core_checker i_banked_core_checker (
  .CLK(CLK), .NRST(NRST), .POR_NRST(POR_NRST), .ACCESS_VALID(ACCESS_VALID),
  .ACCESS_WRITE(ACCESS_WRITE), .FILE_OFFSET(FILE_OFFSET), .WRITE_DATA(WRITE_DATA),
  .ALU_OP(ALU_OP), .ALU_A(ALU_A), .ALU_B(ALU_B), .WATCHDOG_CLEAR(WATCHDOG_CLEAR),
  .SLEEP_EXEC(SLEEP_EXEC), .WATCHDOG_TIMEOUT(WATCHDOG_TIMEOUT), .READ_DATA(READ_DATA),
  .PC_JUMP(PC_JUMP), .PC_JUMP_TARGET(PC_JUMP_TARGET), .STATUS_VALUE(STATUS_VALUE));
`default_nettype wire

// file: core_access_model.sv
// core-side model: one file access at a time on the register port
// assumes reads are answered on the taking edge and valid by the next falling edge
`timescale 1ns/1ps
`default_nettype none

module core_access_model (
  input  wire logic       clk,
  input  wire logic [7:0] read_data,
  input  wire logic       read_valid,
  output var  logic       access_valid,
  output var  logic       access_write,
  output var  logic [6:0] file_offset,
  output var  logic [7:0] write_data,
  output var  logic [2:0] alu_op,
  output var  logic [7:0] alu_a,
  output var  logic [7:0] alu_b,
  output var  logic [7:0] pc_current_low
);
  initial
  begin
    {access_valid, access_write, file_offset, write_data, alu_op, alu_a, alu_b} = 36'h0;
    pc_current_low = 8'h3D;
  end

  // drive at a falling edge, hold past the taking edge
  task automatic xfer(input logic wr, input logic [6:0] ofs, input logic [7:0] data,
                      input logic [2:0] op, input logic [7:0] a, input logic [7:0] b,
                      output logic [7:0] rd);
    @(negedge clk);
    {access_valid, access_write, file_offset, write_data, alu_op, alu_a, alu_b} =
      {1'b1, wr, ofs, data, op, a, b};
    @(negedge clk);
    // a missing or late answer shows up as unknown
    rd = read_valid ? read_data : 8'hXX;
    access_valid = 1'b0;
    // stale data inverted so a late sample cannot pass
    write_data   = ~data;
  endtask
endmodule // core_access_model
`default_nettype wire

// file: banked_core_registers_tb.sv
// self-checking bench: access table, then jump, events, interrupts, resets
// assumes the core model on the file port and the bound checker
`timescale 1ns/1ps
`default_nettype none
`include "banked_core_defs.vh"

module banked_core_registers_tb;
  localparam int N = 52;
  logic        CLK, NRST, POR_NRST, PIN_CHANGE_PENDING, PERIPH_REQUEST;
  logic [4:0]  ev;
  wire         ACCESS_VALID, ACCESS_WRITE, READ_VALID, PC_JUMP, IRQ;
  wire  [6:0]  FILE_OFFSET;
  wire  [2:0]  ALU_OP;
  wire  [7:0]  WRITE_DATA, ALU_A, ALU_B, PC_CURRENT_LOW, READ_DATA, WORKING_VALUE, STATUS_VALUE;
  wire  [14:0] PC_JUMP_TARGET;
  logic [39:0] r;
  logic [7:0]  rd;
  int          n_fail, total_checks;
  // row: write, offset, data or expected read, alu op, operand a, operand b
  logic [39:0] rows [0:N-1] = '{
    40'h1080100000, 40'h1205A00000, 40'h1080000000, 40'h120A500000,
    40'h020A500000, 40'h17F3C00000, 40'h1080100000, 40'h07F3C00000,
    40'h0205A00000, 40'h1080200000, 40'h1207700000, 40'h0200000000,
    40'h01F0000000, 40'h00C0000000, 40'h0080200000, 40'h0023D00000,
    40'h104A000000, 40'h1050000000, 40'h0005A00000, 40'h106FF00000,
    40'h1070F00000, 40'h0013C00000, 40'h1019900000, 40'h07F9900000,
    40'h1071F00000, 40'h0010000000, 40'h004A000000, 40'h1090018888,
    40'h0031B00000, 40'h1090021010, 40'h0031F00000, 40'h1090021021,
    40'h0031800000, 40'h1090030100, 40'h0031900000, 40'h0090000000,
    40'h1090044000, 40'h0098100000, 40'h109005F00F, 40'h0031C00000,
    40'h1090060100, 40'h0031800000, 40'h1090075555, 40'h0031C00000,
    40'h103FF00000, 40'h0031F00000, 40'h1030010000, 40'h0031C00000,
    40'h10A5500000, 40'h00A5500000, 40'h1094200000, 40'h0094200000};

  banked_core_registers i_banked_core_registers (
    .CLK(CLK), .NRST(NRST), .POR_NRST(POR_NRST),
    .ACCESS_VALID(ACCESS_VALID), .ACCESS_WRITE(ACCESS_WRITE),
    .FILE_OFFSET(FILE_OFFSET), .WRITE_DATA(WRITE_DATA), .ALU_OP(ALU_OP),
    .ALU_A(ALU_A), .ALU_B(ALU_B), .PC_CURRENT_LOW(PC_CURRENT_LOW),
    .WATCHDOG_CLEAR(ev[0]), .SLEEP_EXEC(ev[1]), .WATCHDOG_TIMEOUT(ev[2]),
    .TIMER0_OVERFLOW(ev[3]), .EXT_PIN_EVENT(ev[4]),
    .PIN_CHANGE_PENDING(PIN_CHANGE_PENDING), .PERIPH_REQUEST(PERIPH_REQUEST),
    .READ_DATA(READ_DATA), .READ_VALID(READ_VALID), .PC_JUMP(PC_JUMP),
    .PC_JUMP_TARGET(PC_JUMP_TARGET), .WORKING_VALUE(WORKING_VALUE),
    .STATUS_VALUE(STATUS_VALUE), .IRQ(IRQ));

  core_access_model i_core_access_model (
    .clk(CLK), .read_data(READ_DATA), .read_valid(READ_VALID),
    .access_valid(ACCESS_VALID), .access_write(ACCESS_WRITE),
    .file_offset(FILE_OFFSET), .write_data(WRITE_DATA), .alu_op(ALU_OP),
    .alu_a(ALU_A), .alu_b(ALU_B), .pc_current_low(PC_CURRENT_LOW));

  initial
  begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end

  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task conclude;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task acc(input logic w, input logic [6:0] o, input logic [7:0] d, output logic [7:0] q);
    i_core_access_model.xfer(w, o, d, 3'h0, 8'h00, 8'h00, q);
  endtask

  task pulse(input logic [4:0] m);
    @(negedge CLK);
    ev = m;
    @(negedge CLK);
    ev = 5'h00;
  endtask

  task do_reset(input logic por);
    NRST = 1'b0;
    POR_NRST = ~por;
    repeat (6) @(negedge CLK);
    NRST = 1'b1;
    POR_NRST = 1'b1;
  endtask

  // some sixteen times the expected run; a hang ends here
  initial
  begin
    #50us;
    n_fail++;
    conclude;
  end

  initial
  begin
    n_fail = 0;
    total_checks = 0;
    ev = 5'h00;
    PIN_CHANGE_PENDING = 1'b0;
    PERIPH_REQUEST = 1'b0;
    do_reset(1'b1);
    // status rewritten by one plain move and one add in the table
    for (int i = 0; i < N; i++)
    begin
      r = rows[i];
      i_core_access_model.xfer(r[36], r[34:28], r[27:20], r[18:16], r[15:8], r[7:0], rd);
      if (!r[36])
        chk(rd, r[27:20]);
    end
    acc(1'b1, `OFS_PC_LOW, 8'h12, rd);
    chk({1'b0, PC_JUMP_TARGET}, 16'h5512);
    pulse(5'h04);
    chk(STATUS_VALUE, 8'h0C);
    pulse(5'h02);
    chk(STATUS_VALUE, 8'h14);
    pulse(5'h01);
    chk(STATUS_VALUE, 8'h1C);
    pulse(5'h18);
    acc(1'b0, `OFS_INT_CONTROL, 8'h00, rd);
    chk(rd, 8'h06);
    chk(IRQ, 1'b0);
    // flags cleared before enables go up
    acc(1'b1, `OFS_INT_CONTROL, 8'h00, rd);
    acc(1'b1, `OFS_INT_CONTROL, 8'hA0, rd);
    pulse(5'h08);
    @(negedge CLK);
    chk(IRQ, 1'b1);
    acc(1'b1, `OFS_INT_CONTROL, 8'h80, rd);
    PERIPH_REQUEST = 1'b1;
    repeat (2) @(negedge CLK);
    chk(IRQ, 1'b0);
    acc(1'b1, `OFS_INT_CONTROL, 8'hC0, rd);
    @(negedge CLK);
    chk(IRQ, 1'b1);
    PERIPH_REQUEST = 1'b0;
    PIN_CHANGE_PENDING = 1'b1;
    acc(1'b1, `OFS_INT_CONTROL, 8'h88, rd);
    acc(1'b0, `OFS_INT_CONTROL, 8'h00, rd);
    chk(rd, 8'h89);
    chk(IRQ, 1'b1);
    PIN_CHANGE_PENDING = 1'b0;
    acc(1'b0, `OFS_INT_CONTROL, 8'h00, rd);
    chk(rd, 8'h88);
    // ordinary reset keeps the alu flags
    do_reset(1'b0);
    chk(STATUS_VALUE, 8'h1C);
    chk(WORKING_VALUE, 8'h00);
    acc(1'b0, `OFS_INT_CONTROL, 8'h00, rd);
    chk(rd, 8'h00);
    do_reset(1'b1);
    chk(STATUS_VALUE, 8'h18);
    conclude;
  end
endmodule // banked_core_registers_tb
`default_nettype wire
